// [src/dfch_pkg.sv]
// Purpose: shared constants and types of the diagnostic and flash command handler
// Assumes: 16-bit command codes, 32-bit result word at the channel's offset zero
// Notes: every code, index and error value used by the handler lives here
`default_nettype none

package dfch_pkg;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [15:0] CMD_RD_SELFTEST = 16'h3000;
  localparam logic [15:0] CMD_RD_ST_RELAY = 16'h3001;
  localparam logic [15:0] CMD_RD_SWITCH = 16'h3002;
  localparam logic [15:0] CMD_RD_TRIG = 16'h3003;
  localparam logic [15:0] CMD_REF_FIRST = 16'h3004;
  localparam logic [15:0] CMD_REF_LAST = 16'h3009;
  localparam logic [15:0] CMD_RD_ST_MEAS = 16'h300a;
  localparam logic [15:0] CMD_SYSFAIL_ON = 16'h300b;
  localparam logic [15:0] CMD_SYSFAIL_OFF = 16'h300c;
  localparam logic [15:0] CMD_REF_POS_SMALL = 16'h300d;
  localparam logic [15:0] CMD_REF_NEG_SMALL = 16'h300e;
  localparam logic [15:0] CMD_RELAY_OFF = 16'h3010;
  localparam logic [15:0] CMD_RELAY_CH4 = 16'h3011;
  localparam logic [15:0] CMD_RELAY_CH5 = 16'h3012;
  localparam logic [15:0] CMD_RELAY_BOTH = 16'h3013;

  // flash sequence: high byte is the step, low byte the target (1..4)
  localparam logic [7:0] FLASH_ARM_HI = 8'h55;
  localparam logic [7:0] FLASH_CONFIRM_HI = 8'haa;
  localparam logic [7:0] FLASH_TGT_FIRST = 8'h01;
  localparam logic [7:0] FLASH_TGT_LAST = 8'h04;

  // ****************************************
  // relay encodings, bit 0 is channel 4, bit 1 is channel 5
  // ****************************************
  localparam logic [1:0] RELAY_NONE = 2'h0;
  localparam logic [1:0] RELAY_CH4 = 2'h1;
  localparam logic [1:0] RELAY_CH5 = 2'h2;
  localparam logic [1:0] RELAY_BOTH = 2'h3;

  // ****************************************
  // reference store
  // ****************************************
  localparam int REF_COUNT = 8;
  localparam int REF_IDX_W = 3;
  localparam logic [2:0] REF_IDX_POS_SMALL = 3'h6;
  localparam logic [2:0] REF_IDX_NEG_SMALL = 3'h7;

  // ****************************************
  // error codes
  // ****************************************
  localparam logic [15:0] ERR_UNKNOWN_CMD = 16'h0001;
  localparam logic [15:0] ERR_FLASH_BURN = 16'h0205;

  // ****************************************
  // sequence stages and states
  // ****************************************
  localparam logic [1:0] STAGE_IDLE = 2'h0;
  localparam logic [1:0] STAGE_ARMED = 2'h1;
  localparam logic [1:0] STAGE_CONFIRMED = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_REF_RD, ST_FLASH_WAIT} dfch_state_t;

  typedef enum logic [3:0] {
    CLS_REG, CLS_REF, CLS_MEAS, CLS_SF_ON, CLS_SF_OFF, CLS_RELAY, CLS_FLASH, CLS_UNKNOWN
  } dfch_cls_t;

endpackage

`default_nettype wire

// [src/dfch_ref_mem.sv]
// Purpose: store of calibrated reference values read back by diagnostic commands
// Assumes: one write port from the calibration loader, one read port
// Notes: read data is registered, one cycle after the read strobe
`default_nettype none

module dfch_ref_mem #(
  parameter int DEPTH = dfch_pkg::REF_COUNT,
  parameter int AW = dfch_pkg::REF_IDX_W,
  parameter int DW = 32
) (
  // clock
  input wire logic clk,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // read side
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // contents are not reset: the loader fills them after power-up
  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

`default_nettype wire

// [src/dfch_handler.sv]
// Purpose: decodes host command codes, answers diagnostic reads, drives sysfail
//          and the high-speed self-test relays, guards the flash write sequence
// Assumes: commands arrive from same-clock logic; trigger pins are asynchronous
// Notes: the flash engine outside moves the uploaded image and reports back
`default_nettype none

// Summary of operation
// - codes 3000-3003 return four diagnostic registers
// - reference codes return stored calibrated values
// - code 300A returns latest self-test measurements
// - 300B asserts sysfail, 300C releases it
// - codes 3010-3013 set high-speed self-test relays
// - flash written only after three-command guarded sequence
// - 5501, AA01, 5501 replaces processor software
// - 5502, AA02, 5502 replaces first logic image
// - 5503, AA03, 5503 replaces second logic image
// - 5504, AA04, 5504 replaces third logic image
// - wrong order gives no flash write, no effect
// - final step completes only after image in flash
// - new image effective only after next power-up
// - read results go to offset-zero result word
// - unknown command queues error 0x0001
// - failed flash burn queues error 0x0205
module dfch_handler #(
  parameter int TRIG_W = 8
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // command from the host
  input wire logic CMD_VALID,
  input wire logic [15:0] CMD_CODE,
  output logic CMD_BUSY,
  output logic CMD_DONE,
  // result word at offset zero
  output logic RESULT_WE,
  output logic [31:0] RESULT_DATA,
  // diagnostic sources
  input wire logic [15:0] SELFTEST_REG,
  input wire logic [15:0] SELFTEST_RELAY_REG,
  input wire logic [15:0] SWITCH_REG,
  input wire logic [TRIG_W-1:0] TRIG_IN,
  input wire logic [31:0] SELFTEST_MEAS,
  // reference store loading
  input wire logic REF_LOAD_EN,
  input wire logic [dfch_pkg::REF_IDX_W-1:0] REF_LOAD_IDX,
  input wire logic [31:0] REF_LOAD_DATA,
  // backplane and relays
  output logic SYSFAIL,
  output logic [1:0] HS_RELAY,
  // flash engine
  output logic FLASH_REQ,
  output logic [1:0] FLASH_TARGET,
  input wire logic FLASH_DONE,
  input wire logic FLASH_ERR,
  output logic [3:0] IMAGE_PENDING,
  // error queue
  output logic ERR_PUSH,
  output logic [15:0] ERR_CODE
);

  // ****************************************
  // decoding
  // ****************************************
  function automatic dfch_pkg::dfch_cls_t classify(input logic [15:0] code);
    logic [7:0] lo;
    lo = code[7:0];
    if (code >= dfch_pkg::CMD_RD_SELFTEST && code <= dfch_pkg::CMD_RD_TRIG) begin
      classify = dfch_pkg::CLS_REG;
    end else if ((code >= dfch_pkg::CMD_REF_FIRST && code <= dfch_pkg::CMD_REF_LAST) ||
                 code == dfch_pkg::CMD_REF_POS_SMALL || code == dfch_pkg::CMD_REF_NEG_SMALL) begin
      classify = dfch_pkg::CLS_REF;
    end else if (code == dfch_pkg::CMD_RD_ST_MEAS) begin
      classify = dfch_pkg::CLS_MEAS;
    end else if (code == dfch_pkg::CMD_SYSFAIL_ON) begin
      classify = dfch_pkg::CLS_SF_ON;
    end else if (code == dfch_pkg::CMD_SYSFAIL_OFF) begin
      classify = dfch_pkg::CLS_SF_OFF;
    end else if (code >= dfch_pkg::CMD_RELAY_OFF && code <= dfch_pkg::CMD_RELAY_BOTH) begin
      classify = dfch_pkg::CLS_RELAY;
    end else if ((code[15:8] == dfch_pkg::FLASH_ARM_HI || code[15:8] == dfch_pkg::FLASH_CONFIRM_HI) &&
                 lo >= dfch_pkg::FLASH_TGT_FIRST && lo <= dfch_pkg::FLASH_TGT_LAST) begin
      classify = dfch_pkg::CLS_FLASH;
    end else begin
      classify = dfch_pkg::CLS_UNKNOWN;
    end
  endfunction

  dfch_pkg::dfch_state_t state_q;
  dfch_pkg::dfch_cls_t cls;
  logic take;
  logic [TRIG_W-1:0] trig_meta_q;
  logic [TRIG_W-1:0] trig_q;
  logic [1:0] stage_q;
  logic [1:0] seq_tgt_q;
  logic [1:0] cmd_tgt;
  logic is_arm;
  logic is_confirm;
  logic burn_go;
  logic [dfch_pkg::REF_IDX_W-1:0] ref_idx;
  logic [31:0] ref_rdata;
  logic [31:0] result_q;
  logic result_we_q;
  logic done_q;
  logic sysfail_q;
  logic [1:0] relay_q;
  logic flash_req_q;
  logic [1:0] flash_tgt_q;
  logic [3:0] pending_q;
  logic err_push_q;
  logic [15:0] err_code_q;

  // a new command is refused while one is still running
  assign take = CMD_VALID && state_q == dfch_pkg::ST_IDLE;
  assign cls = classify(CMD_CODE);
  assign cmd_tgt = 2'(CMD_CODE[1:0] - 2'h1);
  assign is_arm = CMD_CODE[15:8] == dfch_pkg::FLASH_ARM_HI;
  assign is_confirm = CMD_CODE[15:8] == dfch_pkg::FLASH_CONFIRM_HI;

  // ****************************************
  // trigger pin synchroniser
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      trig_meta_q <= '0;
      trig_q <= '0;
    end else begin
      trig_meta_q <= TRIG_IN;
      trig_q <= trig_meta_q;
    end
  end

  // ****************************************
  // command state
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_q <= dfch_pkg::ST_IDLE;
    end else begin
      case (state_q)
        dfch_pkg::ST_IDLE: begin
          if (take && cls == dfch_pkg::CLS_REF) begin
            state_q <= dfch_pkg::ST_REF_RD;
          end else if (burn_go) begin
            state_q <= dfch_pkg::ST_FLASH_WAIT;
          end
        end
        dfch_pkg::ST_REF_RD: state_q <= dfch_pkg::ST_IDLE;
        dfch_pkg::ST_FLASH_WAIT: begin
          if (FLASH_DONE) begin
            state_q <= dfch_pkg::ST_IDLE;
          end
        end
        default: state_q <= dfch_pkg::ST_IDLE;
      endcase
    end
  end

  assign CMD_BUSY = state_q != dfch_pkg::ST_IDLE;

  // ****************************************
  // flash guard sequence
  // ****************************************
  // the closing arm step of a matching sequence starts the burn
  assign burn_go = take && cls == dfch_pkg::CLS_FLASH && stage_q == dfch_pkg::STAGE_CONFIRMED &&
                   is_arm && cmd_tgt == seq_tgt_q;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      stage_q <= dfch_pkg::STAGE_IDLE;
      seq_tgt_q <= 2'h0;
    end else if (take) begin
      if (cls == dfch_pkg::CLS_FLASH && stage_q == dfch_pkg::STAGE_IDLE && is_arm) begin
        stage_q <= dfch_pkg::STAGE_ARMED;
        seq_tgt_q <= cmd_tgt;
      end else if (cls == dfch_pkg::CLS_FLASH && stage_q == dfch_pkg::STAGE_ARMED && is_confirm &&
                   cmd_tgt == seq_tgt_q) begin
        stage_q <= dfch_pkg::STAGE_CONFIRMED;
      end else begin
        // anything else drops the partial sequence without effect
        stage_q <= dfch_pkg::STAGE_IDLE;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      flash_req_q <= 1'b0;
      flash_tgt_q <= 2'h0;
    end else begin
      flash_req_q <= burn_go;
      if (burn_go) begin
        flash_tgt_q <= seq_tgt_q;
      end
    end
  end

  // the running code is untouched; the new image waits for power-up
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pending_q <= 4'h0;
    end else if (state_q == dfch_pkg::ST_FLASH_WAIT && FLASH_DONE && !FLASH_ERR) begin
      pending_q[flash_tgt_q] <= 1'b1;
    end
  end

  // ****************************************
  // reference store
  // ****************************************
  always_comb begin
    if (CMD_CODE == dfch_pkg::CMD_REF_POS_SMALL) begin
      ref_idx = dfch_pkg::REF_IDX_POS_SMALL;
    end else if (CMD_CODE == dfch_pkg::CMD_REF_NEG_SMALL) begin
      ref_idx = dfch_pkg::REF_IDX_NEG_SMALL;
    end else begin
      ref_idx = 3'(CMD_CODE - dfch_pkg::CMD_REF_FIRST);
    end
  end

  dfch_ref_mem u_ref_mem (
    .clk(CLK_SYS),
    .wr_en(REF_LOAD_EN),
    .wr_addr(REF_LOAD_IDX),
    .wr_data(REF_LOAD_DATA),
    .rd_en(take && cls == dfch_pkg::CLS_REF),
    .rd_addr(ref_idx),
    .rd_data(ref_rdata)
  );

  // ****************************************
  // result word
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      result_q <= 32'h0;
      result_we_q <= 1'b0;
    end else begin
      result_we_q <= 1'b0;
      if (state_q == dfch_pkg::ST_REF_RD) begin
        result_q <= ref_rdata;
        result_we_q <= 1'b1;
      end else if (take && cls == dfch_pkg::CLS_REG) begin
        result_we_q <= 1'b1;
        case (CMD_CODE[1:0])
          2'h0: result_q <= {16'h0, SELFTEST_REG};
          2'h1: result_q <= {16'h0, SELFTEST_RELAY_REG};
          2'h2: result_q <= {16'h0, SWITCH_REG};
          default: result_q <= 32'(trig_q);
        endcase
      end else if (take && cls == dfch_pkg::CLS_MEAS) begin
        result_q <= SELFTEST_MEAS;
        result_we_q <= 1'b1;
      end
    end
  end

  // completion pulse: at once for direct commands, after the store or burn otherwise
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (take && cls != dfch_pkg::CLS_REF && !burn_go) || state_q == dfch_pkg::ST_REF_RD ||
                (state_q == dfch_pkg::ST_FLASH_WAIT && FLASH_DONE);
    end
  end

  // ****************************************
  // sysfail and relays
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sysfail_q <= 1'b0;
    end else if (take && cls == dfch_pkg::CLS_SF_ON) begin
      sysfail_q <= 1'b1;
    end else if (take && cls == dfch_pkg::CLS_SF_OFF) begin
      sysfail_q <= 1'b0;
    end
  end

  // both relays on is allowed though abnormal
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      relay_q <= dfch_pkg::RELAY_NONE;
    end else if (take && cls == dfch_pkg::CLS_RELAY) begin
      case (CMD_CODE[1:0])
        2'h0: relay_q <= dfch_pkg::RELAY_NONE;
        2'h1: relay_q <= dfch_pkg::RELAY_CH4;
        2'h2: relay_q <= dfch_pkg::RELAY_CH5;
        default: relay_q <= dfch_pkg::RELAY_BOTH;
      endcase
    end
  end

  // ****************************************
  // error reporting
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      err_push_q <= 1'b0;
      err_code_q <= 16'h0;
    end else begin
      err_push_q <= 1'b0;
      if (take && cls == dfch_pkg::CLS_UNKNOWN) begin
        err_push_q <= 1'b1;
        err_code_q <= dfch_pkg::ERR_UNKNOWN_CMD;
      end else if (state_q == dfch_pkg::ST_FLASH_WAIT && FLASH_DONE && FLASH_ERR) begin
        err_push_q <= 1'b1;
        err_code_q <= dfch_pkg::ERR_FLASH_BURN;
      end
    end
  end

  assign CMD_DONE = done_q;
  assign RESULT_WE = result_we_q;
  assign RESULT_DATA = result_q;
  assign SYSFAIL = sysfail_q;
  assign HS_RELAY = relay_q;
  assign FLASH_REQ = flash_req_q;
  assign FLASH_TARGET = flash_tgt_q;
  assign IMAGE_PENDING = pending_q;
  assign ERR_PUSH = err_push_q;
  assign ERR_CODE = err_code_q;

  // ****************************************
  // checks
  // ****************************************
  selftest_read_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    take && CMD_CODE == dfch_pkg::CMD_RD_SELFTEST |=> RESULT_WE && RESULT_DATA == {16'h0, $past(SELFTEST_REG)})
    else $error("self-test register read wrong");

  ref_read_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    take && cls == dfch_pkg::CLS_REF |=> !RESULT_WE ##1 RESULT_WE && CMD_DONE && !CMD_BUSY)
    else $error("reference read not answered in two cycles");

  meas_read_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    take && cls == dfch_pkg::CLS_MEAS |=> RESULT_WE && RESULT_DATA == $past(SELFTEST_MEAS))
    else $error("self-test measurement read wrong");

  sysfail_ctrl_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    $changed(SYSFAIL) |-> $past(take) && ($past(cls) == (SYSFAIL ? dfch_pkg::CLS_SF_ON : dfch_pkg::CLS_SF_OFF)))
    else $error("sysfail changed without its command");

  relay_ch5_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    take && CMD_CODE == dfch_pkg::CMD_RELAY_CH5 |=> HS_RELAY == dfch_pkg::RELAY_CH5)
    else $error("channel 5 relay selection wrong");

  flash_guard_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    FLASH_REQ |-> $past(stage_q) == dfch_pkg::STAGE_CONFIRMED && $past(take) && FLASH_TARGET == $past(seq_tgt_q))
    else $error("flash request without complete sequence");

  wrong_order_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    take && is_confirm && stage_q == dfch_pkg::STAGE_IDLE |=> stage_q == dfch_pkg::STAGE_IDLE ##1 !FLASH_REQ)
    else $error("confirm step out of order had an effect");

  seq_discard_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    take && cls != dfch_pkg::CLS_FLASH |=> stage_q == dfch_pkg::STAGE_IDLE)
    else $error("partial flash sequence survived other command");

  burn_done_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    CMD_DONE && $past(state_q) == dfch_pkg::ST_FLASH_WAIT |-> $past(FLASH_DONE))
    else $error("flash step completed before image burned");

  unknown_err_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    take && cls == dfch_pkg::CLS_UNKNOWN |=> ERR_PUSH && ERR_CODE == dfch_pkg::ERR_UNKNOWN_CMD && CMD_DONE)
    else $error("unknown command not queued as error");

  burn_err_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    state_q == dfch_pkg::ST_FLASH_WAIT && FLASH_DONE && FLASH_ERR |=> ERR_PUSH && ERR_CODE == dfch_pkg::ERR_FLASH_BURN)
    else $error("failed burn not queued as error");

endmodule

`default_nettype wire

// [verification/dfch_flash_model.sv]
// Purpose: behavioural flash engine facing the command handler
// Assumes: same clock as the handler, one burn at a time
// Notes: a burn fails when the requested target differs from the uploaded image
`default_nettype none

module dfch_flash_model #(
  parameter int BURN_CYCLES = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request from the handler
  input wire logic req,
  input wire logic [1:0] target,
  // image kind that the host placed at offset zero
  input wire logic [1:0] img_target,
  // completion
  output logic done,
  output logic err
);
  timeunit 1ns;
  timeprecision 1ps;

  int cnt_q;
  logic [1:0] tgt_q;

  // ****************************************
  // burn timing and outcome
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 0;
      tgt_q <= 2'h0;
      done <= 1'b0;
      err <= 1'b0;
    end else if (req) begin
      cnt_q <= BURN_CYCLES;
      tgt_q <= target;
      done <= 1'b0;
      err <= ~err;
    end else begin
      cnt_q <= (cnt_q != 0) ? cnt_q - 1 : 0;
      done <= (cnt_q == 1);
      // outside the done pulse the error line toggles, so it is never read by luck
      err <= (cnt_q == 1) ? (tgt_q != img_target) : ~err;
    end
  end
endmodule

`default_nettype wire

// [verification/dfch_handler_tb.sv]
// Purpose: self-checking bench of the diagnostic and flash command handler
// Assumes: flash engine model answers after a fixed burn time
// Notes: table of direct commands first, then sequences and reset by hand
`default_nettype none

`define CHK_EQ(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); \
  end \
end

module dfch_handler_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int BURN = 12;

  typedef struct {
    logic [15:0] code;
    logic [31:0] exp;
    logic [1:0] kind;
    int lat;
  } dfch_row_t;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [15:0] cmd_code = 16'h0;
  logic busy, done, result_we, sysfail, flash_req, flash_done, flash_err, err_push;
  logic [31:0] result_data;
  logic [1:0] hs_relay, flash_target, req_tgt;
  logic [3:0] image_pending;
  logic [15:0] err_code;
  logic ref_en = 1'b0;
  logic [2:0] ref_idx = 3'h0;
  logic [31:0] ref_data = 32'h0;
  logic [1:0] img_target = 2'h0;
  logic [7:0] trig = 8'ha5;
  logic [31:0] meas = 32'hdeadbeef;
  logic got_we, got_err, got_done;
  int lat, n_req, n_mismatch, cmp_count, nd, n0;

  // kind: 0 result word, 1 sysfail, 2 relays, 3 error queue
  dfch_row_t rows[21] = '{
    '{16'h3000, 32'h0000_1234, 2'h0, 1},
    '{16'h3001, 32'h0000_5678, 2'h0, 1},
    '{16'h3002, 32'h0000_9abc, 2'h0, 1},
    '{16'h3003, 32'h0000_00a5, 2'h0, 1},
    '{16'h3004, 32'h5a00_0000, 2'h0, 2},
    '{16'h3005, 32'h5a00_0001, 2'h0, 2},
    '{16'h3006, 32'h5a00_0002, 2'h0, 2},
    '{16'h3007, 32'h5a00_0003, 2'h0, 2},
    '{16'h3008, 32'h5a00_0004, 2'h0, 2},
    '{16'h3009, 32'h5a00_0005, 2'h0, 2},
    '{16'h300d, 32'h5a00_0006, 2'h0, 2},
    '{16'h300e, 32'h5a00_0007, 2'h0, 2},
    '{16'h300a, 32'hdead_beef, 2'h0, 1},
    '{16'h300b, 32'h0000_0001, 2'h1, 1},
    '{16'h300c, 32'h0000_0000, 2'h1, 1},
    '{16'h3011, 32'h0000_0001, 2'h2, 1},
    '{16'h3012, 32'h0000_0002, 2'h2, 1},
    '{16'h3013, 32'h0000_0003, 2'h2, 1},
    '{16'h3010, 32'h0000_0000, 2'h2, 1},
    '{16'h300f, 32'h0000_0001, 2'h3, 1},
    '{16'h4000, 32'h0000_0001, 2'h3, 1}
  };

  // ends with the handler idle, so a later sequence starts clean
  logic [15:0] bad[14] = '{16'haa01, 16'h5501, 16'h5501, 16'h5502, 16'h3000, 16'haa02, 16'h5502,
    16'h5503, 16'haa04, 16'h5503, 16'h5504, 16'h5504, 16'haa04, 16'h3000};

  always #2 clk = ~clk;

  dfch_handler #(
    .TRIG_W(8)
  ) i_dut (
    .CLK_SYS(clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_BUSY(busy),
    .CMD_DONE(done), .RESULT_WE(result_we), .RESULT_DATA(result_data),
    .SELFTEST_REG(16'h1234), .SELFTEST_RELAY_REG(16'h5678), .SWITCH_REG(16'h9abc),
    .TRIG_IN(trig), .SELFTEST_MEAS(meas), .REF_LOAD_EN(ref_en), .REF_LOAD_IDX(ref_idx),
    .REF_LOAD_DATA(ref_data), .SYSFAIL(sysfail), .HS_RELAY(hs_relay), .FLASH_REQ(flash_req),
    .FLASH_TARGET(flash_target), .FLASH_DONE(flash_done), .FLASH_ERR(flash_err),
    .IMAGE_PENDING(image_pending), .ERR_PUSH(err_push), .ERR_CODE(err_code)
  );

  dfch_flash_model #(
    .BURN_CYCLES(BURN)
  ) i_flash (
    .clk(clk), .rst(rst), .req(flash_req), .target(flash_target), .img_target(img_target),
    .done(flash_done), .err(flash_err)
  );

  always @(posedge clk) begin
    if (flash_req === 1'b1) begin
      n_req++;
      req_tgt = flash_target;
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one command; lat counts edges from the take edge to the done pulse
  task automatic issue(input logic [15:0] c);
    got_we = 1'b0;
    got_err = 1'b0;
    got_done = 1'b0;
    lat = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (got_done == 1'b0 && lat < 200) begin
      @(posedge clk);
      lat++;
      got_done = (done === 1'b1);
      got_we = got_we | (result_we === 1'b1);
      got_err = got_err | (err_push === 1'b1);
    end
    if (got_done == 1'b0) begin
      n_mismatch++;
      summarize();
    end
  endtask

  // host waits for each step before the next one
  task automatic flash_seq(input logic [7:0] t);
    n0 = n_req;
    issue({8'h55, t});
    issue({8'haa, t});
    `CHK_EQ(n_req, n0)
    issue({8'h55, t});
    // take, request, engine start, burn count, done sampled by the handler
    `CHK_EQ(lat, BURN + 3)
  endtask

  initial begin
    n_req = 0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      ref_en <= 1'b1;
      ref_idx <= 3'(i);
      ref_data <= 32'h5a00_0000 + 32'(i);
    end
    @(posedge clk);
    ref_en <= 1'b0;
    foreach (rows[k]) begin
      issue(rows[k].code);
      `CHK_EQ(lat, rows[k].lat)
      `CHK_EQ(got_err, rows[k].kind == 2'h3)
      case (rows[k].kind)
        2'h0: begin
          `CHK_EQ(got_we, 1'b1)
          `CHK_EQ(result_data, rows[k].exp)
        end
        2'h1: `CHK_EQ(sysfail, rows[k].exp[0])
        2'h2: `CHK_EQ(hs_relay, rows[k].exp[1:0])
        default: `CHK_EQ(err_code, rows[k].exp[15:0])
      endcase
    end
    $display("test table done");
    nd = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= 16'h3011;
    @(posedge clk);
    cmd_code <= 16'h3012;
    @(posedge clk);
    cmd_valid <= 1'b0;
    nd += (done === 1'b1);
    @(posedge clk);
    nd += (done === 1'b1);
    `CHK_EQ(nd, 2)
    `CHK_EQ(hs_relay, 2'h2)
    $display("test back_to_back done");
    // a command held up while a reference read runs must be dropped
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= 16'h3004;
    @(posedge clk);
    cmd_code <= 16'h300b;
    @(posedge clk);
    cmd_valid <= 1'b0;
    `CHK_EQ(busy, 1'b1)
    @(posedge clk);
    `CHK_EQ(busy, 1'b0)
    `CHK_EQ(sysfail, 1'b0)
    `CHK_EQ(result_data, 32'h5a00_0000)
    // trigger pins pass two flops before a read sees them
    trig <= 8'h3c;
    repeat (2) @(posedge clk);
    issue(16'h3003);
    `CHK_EQ(result_data, 32'h0000_003c)
    $display("test busy_refuse done");
    foreach (bad[k]) begin
      issue(bad[k]);
      `CHK_EQ(got_err, 1'b0)
    end
    `CHK_EQ(n_req, 0)
    `CHK_EQ(image_pending, 4'h0)
    $display("test bad_order done");
    img_target <= 2'h0;
    flash_seq(8'h02);
    `CHK_EQ(got_err, 1'b1)
    `CHK_EQ(err_code, 16'h0205)
    `CHK_EQ(image_pending, 4'h0)
    $display("test burn_error done");
    for (int t = 1; t <= 4; t++) begin
      img_target <= 2'(t - 1);
      flash_seq(8'(t));
      `CHK_EQ(req_tgt, 2'(t - 1))
      `CHK_EQ(image_pending[t - 1], 1'b1)
      `CHK_EQ(got_err, 1'b0)
    end
    `CHK_EQ(n_req, 5)
    $display("test flash_good done");
    issue(16'h3000);
    `CHK_EQ(image_pending, 4'hf)
    issue(16'h300b);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK_EQ(image_pending, 4'h0)
    `CHK_EQ(sysfail, 1'b0)
    `CHK_EQ(hs_relay, 2'h0)
    $display("test reset done");
    summarize();
  end
endmodule

`default_nettype wire
